// ### design/buck_setpoint_jog_control.sv
// set-point jog control for the two core buck switchers, APB slave
//
// Design decisions made here: register access over APB and the placing of the registers.
module buck_setpoint_jog_control (
   input wire logic clk,
   input wire logic rstn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic serialClk,
   input wire logic selectPinOne,
   input wire logic selectPinTwo,
   input wire logic standbyPin,
   input wire logic secondaryStandbyIn,
   output logic [4:0] buckOneCode,
   output logic [4:0] buckTwoCode
);
   typedef struct packed {
      logic ready;
      logic slvErr;
      logic [31:0] rdata;
      logic jogEn;
      logic [1:0] delaySel;
      logic [1:0][jog_pkg::CFG_W-1:0] cfg;
      logic [1:0] selMeta;
      logic [1:0] selSync;
      logic [1:0][2:0] edgeMeta;
      logic [1:0][2:0] edgeSync;
      logic [1:0][2:0] edgePrev;
      logic [1:0] sbyMeta;
      logic [1:0] sbySync;
      logic [1:0] selPrev;
      logic [1:0] seenOne;
      logic [1:0] seenMore;
      logic [1:0][4:0] jogCode;
      logic [1:0][4:0] outCode;
      logic [1:0][9:0] timer;
      jog_pkg::sleep_state_t sleep;
      logic [10:0] delayCnt;
      logic jogEnPrev;
   } core_state_t;

   core_state_t s;
   core_state_t d;
   jog_link_if linkOne ();
   jog_link_if linkTwo ();
   logic [1:0][2:0] edgeRaw;

   // pulled out of a five-bit field of a switcher configuration word
   function automatic logic [4:0] field5(input logic [jog_pkg::CFG_W-1:0] cfg,
                                          input int lsb);
      field5 = cfg[lsb +: 5];
   endfunction

   // step period in cycles for a rate code
   function automatic logic [9:0] stepCycles(input logic [1:0] rate);
      stepCycles = jog_pkg::STEP_BASE_CYC << rate;
   endfunction

   // address decode shared by write and error paths
   function automatic logic regHit(input logic [7:0] addr);
      regHit = (addr == jog_pkg::CTRL_OFS) || (addr == jog_pkg::BUCK_ONE_OFS) ||
         (addr == jog_pkg::BUCK_TWO_OFS) || (addr == jog_pkg::STATUS_OFS);
   endfunction

   // the link-side counters run on the serial clock
   assign linkOne.sel = selectPinOne;
   assign linkTwo.sel = selectPinTwo;

   jog_edge_counter counterOne (
      .serialClk(serialClk),
      .rstn(rstn),
      .link(linkOne)
   );

   jog_edge_counter counterTwo (
      .serialClk(serialClk),
      .rstn(rstn),
      .link(linkTwo)
   );

   assign edgeRaw[0] = linkOne.edgeSeen;
   assign edgeRaw[1] = linkTwo.edgeSeen;

   // next-state logic for bus, synchronisers, standby and both switchers
   always_comb begin
      logic access;
      logic wrCfg;
      logic sbyReq;
      logic sbyExit;
      logic jogLive;
      logic [2:0] rise;
      logic pulseEnd;
      logic busy;
      logic [4:0] normalNew;
      logic [4:0] normalOld;
      logic [4:0] lowerStop;
      logic [4:0] upperStop;
      logic [4:0] target;
      logic [7:0] cfgOfs;
      access = 1'b0;
      wrCfg = 1'b0;
      sbyReq = 1'b0;
      sbyExit = 1'b0;
      jogLive = 1'b0;
      rise = '0;
      pulseEnd = 1'b0;
      busy = 1'b0;
      normalNew = '0;
      normalOld = '0;
      lowerStop = '0;
      upperStop = '0;
      target = '0;
      cfgOfs = '0;
      d = s;

      // two stages on every pin-side or link-side level
      d.selMeta = {selectPinTwo, selectPinOne};
      d.selSync = s.selMeta;
      d.edgeMeta = edgeRaw;
      d.edgeSync = s.edgeMeta;
      d.edgePrev = s.edgeSync;
      d.sbyMeta = {secondaryStandbyIn, standbyPin};
      d.sbySync = s.sbyMeta;
      d.selPrev = s.selSync;
      d.jogEnPrev = s.jogEn;

      // bus: answer is prepared in the setup cycle, one wait-free access
      d.ready = psel & ~penable;
      d.slvErr = 1'b0;
      if (psel && !penable) begin
         d.slvErr = ~regHit(paddr);
         d.rdata = '0;
         case (paddr)
            jog_pkg::CTRL_OFS: begin
               d.rdata[jog_pkg::JOG_EN_BIT] = s.jogEn;
               d.rdata[jog_pkg::DELAY_LSB +: 2] = s.delaySel;
            end
            jog_pkg::BUCK_ONE_OFS: begin
               d.rdata[jog_pkg::CFG_W-1:0] = s.cfg[0];
            end
            jog_pkg::BUCK_TWO_OFS: begin
               d.rdata[jog_pkg::CFG_W-1:0] = s.cfg[1];
            end
            jog_pkg::STATUS_OFS: begin
               // live state: delivered codes, jog copies, sleep state
               d.rdata[4:0] = s.outCode[0];
               d.rdata[9:5] = s.outCode[1];
               d.rdata[14:10] = s.jogCode[0];
               d.rdata[19:15] = s.jogCode[1];
               d.rdata[21:20] = s.sleep;
            end
            default: begin
               d.rdata = '0;
            end
         endcase
      end
      access = psel & penable & s.ready;
      if (access && pwrite && regHit(paddr)) begin
         if (paddr == jog_pkg::CTRL_OFS) begin
            d.jogEn = pwdata[jog_pkg::JOG_EN_BIT];
            d.delaySel = pwdata[jog_pkg::DELAY_LSB +: 2];
         end
         if (paddr == jog_pkg::BUCK_ONE_OFS) begin
            d.cfg[0] = pwdata[jog_pkg::CFG_W-1:0];
         end
         if (paddr == jog_pkg::BUCK_TWO_OFS) begin
            d.cfg[1] = pwdata[jog_pkg::CFG_W-1:0];
         end
      end

      // standby sequencing, both inputs must be asserted
      sbyReq = &s.sbySync;
      case (s.sleep)
         jog_pkg::AWAKE: begin
            if (sbyReq) begin
               d.sleep = jog_pkg::WAITING;
               d.delayCnt = 11'(s.delaySel * jog_pkg::DELAY_UNIT_CYC);
            end
         end
         jog_pkg::WAITING: begin
            if (!sbyReq) begin
               d.sleep = jog_pkg::AWAKE;
            end else if (s.delayCnt == '0) begin
               d.sleep = jog_pkg::ASLEEP;
            end else begin
               d.delayCnt = s.delayCnt - 11'h001;
            end
         end
         jog_pkg::ASLEEP: begin
            if (!sbyReq) begin
               d.sleep = jog_pkg::AWAKE;
               sbyExit = 1'b1;
            end
         end
         default: begin
            d.sleep = jog_pkg::AWAKE;
         end
      endcase

      // jog commands only act while awake with jog mode on
      jogLive = s.jogEn & (s.sleep == jog_pkg::AWAKE);

      for (int i = 0; i < 2; i++) begin
         cfgOfs = (i == 0) ? jog_pkg::BUCK_ONE_OFS : jog_pkg::BUCK_TWO_OFS;
         wrCfg = access & pwrite & (paddr == cfgOfs);
         normalOld = field5(s.cfg[i], jog_pkg::NORMAL_LSB);
         normalNew = field5(d.cfg[i], jog_pkg::NORMAL_LSB);
         lowerStop = {1'b0, s.cfg[i][jog_pkg::LOWER_LSB +: 4]};
         upperStop = {1'b1, s.cfg[i][jog_pkg::UPPER_LSB +: 4]};

         // select pin chooses alternate only outside jog mode
         if (s.sleep == jog_pkg::ASLEEP) begin
            target = field5(s.cfg[i], jog_pkg::STANDBY_LSB);
         end else if (s.jogEn) begin
            target = s.jogCode[i];
         end else if (s.selSync[i]) begin
            target = field5(s.cfg[i], jog_pkg::ALT_LSB);
         end else begin
            target = normalOld;
         end
         // a step still running blocks new up and down commands
         busy = (s.timer[i] != '0) || (s.outCode[i] != target);

         rise = s.edgeSync[i] & ~s.edgePrev[i];
         pulseEnd = s.selPrev[i] & ~s.selSync[i];
         if (pulseEnd) begin
            d.seenOne[i] = 1'b0;
            d.seenMore[i] = 1'b0;
         end
         // edge counts are sticky; a coincident edge wins over the clear
         if (rise[0]) begin
            d.seenOne[i] = 1'b1;
         end
         if (rise[1]) begin
            d.seenMore[i] = 1'b1;
         end

         if (jogLive) begin
            // third edge acts regardless of busy
            if (rise[2]) begin
               // head back to the normal code
               d.jogCode[i] = normalOld;
            end else if (rise[1] && !busy) begin
               if (s.jogCode[i] < upperStop) begin
                  d.jogCode[i] = s.jogCode[i] + 5'h01;
               end
            end else if (pulseEnd && !busy && (s.seenOne[i] || rise[0]) &&
                         !s.seenMore[i] && !rise[1]) begin
               if (s.jogCode[i] > lowerStop) begin
                  d.jogCode[i] = s.jogCode[i] - 5'h01;
               end
            end
         end

         if (s.jogEn && !s.jogEnPrev) begin
            d.jogCode[i] = normalOld;
         end
         // a changed normal code is the new baseline
         if (wrCfg && (normalNew != normalOld)) begin
            d.jogCode[i] = normalNew;
         end
         if (sbyExit) begin
            d.jogCode[i] = normalOld;
         end

         // only the copy moves; delivered code walks toward the target
         if (s.timer[i] != '0) begin
            d.timer[i] = s.timer[i] - 10'h001;
         end else if (s.outCode[i] != target) begin
            d.timer[i] = stepCycles(s.cfg[i][jog_pkg::RATE_LSB +: 2]) - 10'h001;
            if (s.outCode[i] < target) begin
               d.outCode[i] = s.outCode[i] + 5'h01;
            end else begin
               d.outCode[i] = s.outCode[i] - 5'h01;
            end
         end
      end
   end

   // one register bank for the whole core state
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         s <= '0;
         s.cfg <= {jog_pkg::CFG_RST, jog_pkg::CFG_RST};
         s.jogCode <= {jog_pkg::NORMAL_RST, jog_pkg::NORMAL_RST};
         s.outCode <= {jog_pkg::NORMAL_RST, jog_pkg::NORMAL_RST};
         s.sleep <= jog_pkg::AWAKE;
      end else begin
         s <= d;
      end
   end

   // outputs straight from the state flops
   assign prdata = s.rdata;
   assign pready = s.ready;
   assign pslverr = s.slvErr;
   assign buckOneCode = s.outCode[0];
   assign buckTwoCode = s.outCode[1];
endmodule

// ### design/jog_pkg.sv
// constants, field layout and state codes for the set-point jog block
package jog_pkg;
   // register byte offsets
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] BUCK_ONE_OFS = 8'h04;
   localparam logic [7:0] BUCK_TWO_OFS = 8'h08;
   localparam logic [7:0] STATUS_OFS = 8'h0C;
   // control field positions
   localparam int JOG_EN_BIT = 0;
   localparam int DELAY_LSB = 1;
   // per-switcher configuration field positions
   localparam int NORMAL_LSB = 0;
   localparam int ALT_LSB = 5;
   localparam int STANDBY_LSB = 10;
   localparam int RATE_LSB = 15;
   localparam int LOWER_LSB = 17;
   localparam int UPPER_LSB = 21;
   localparam int CFG_W = 25;
   // reset values
   localparam logic [4:0] NORMAL_RST = 5'h1A;
   localparam logic [4:0] ALT_RST = 5'h1A;
   localparam logic [4:0] STANDBY_RST = 5'h10;
   localparam logic [1:0] RATE_RST = 2'h1;
   localparam logic [3:0] LOWER_RST = 4'h8;
   localparam logic [3:0] UPPER_RST = 4'hA;
   localparam logic [CFG_W-1:0] CFG_RST = {UPPER_RST, LOWER_RST, RATE_RST,
      STANDBY_RST, ALT_RST, NORMAL_RST};
   // timing
   localparam int CLK_PERIOD_NS = 20;
   localparam int STEP_BASE_NS = 2000;
   localparam logic [9:0] STEP_BASE_CYC = 10'(STEP_BASE_NS / CLK_PERIOD_NS);
   localparam int DELAY_UNIT_NS = 10000;
   localparam logic [10:0] DELAY_UNIT_CYC = 11'(DELAY_UNIT_NS / CLK_PERIOD_NS);
   // standby sequencing, gray coded along the path
   typedef enum logic [1:0] {
      AWAKE = 2'h0,
      WAITING = 2'h1,
      ASLEEP = 2'h3
   } sleep_state_t;
endpackage

// ### design/jog_link_if.sv
// signals between a select pin edge counter and the control core
interface jog_link_if;
   logic sel;
   logic [2:0] edgeSeen;
   modport counter (input sel, output edgeSeen);
   modport core (output sel, input edgeSeen);
endinterface

// ### design/jog_edge_counter.sv
// counts serial clock falling edges while a select pin is high
module jog_edge_counter (
   input wire logic serialClk,
   input wire logic rstn,
   jog_link_if.counter link
);
   typedef struct packed {
      logic [2:0] seen;
   } count_state_t;

   count_state_t s;
   count_state_t d;
   logic clearN;

   // the pulse end itself clears, since the clock may stop afterwards
   assign clearN = rstn & link.sel;

   // thermometer: one bit per edge so each crossing bit only rises
   always_comb begin
      d = s;
      d.seen = {s.seen[1:0], 1'b1};
   end

   always_ff @(negedge serialClk or negedge clearN) begin
      if (!clearN) begin
         s <= '0;
      end else begin
         s <= d;
      end
   end

   assign link.edgeSeen = s.seen;
endmodule

// ### testbench/jog_control_checker.sv
// assertion checker for the set-point jog block, bound to its top
module jog_control_checker (
   input wire logic clk,
   input wire logic rstn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic serialClk,
   input wire logic selectPinOne,
   input wire logic selectPinTwo,
   input wire logic standbyPin,
   input wire logic secondaryStandbyIn,
   input wire logic [4:0] buckOneCode,
   input wire logic [4:0] buckTwoCode
);
   logic [9:0] gapOne_q;
   logic [9:0] gapTwo_q;
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   // cycles since each code last moved, saturating so it never wraps
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         gapOne_q <= 10'h3FF;
         gapTwo_q <= 10'h3FF;
      end else begin
         gapOne_q <= $changed(buckOneCode) ? 10'h0 : gapOne_q + {9'h0, gapOne_q != 10'h3FF};
         gapTwo_q <= $changed(buckTwoCode) ? 10'h0 : gapTwo_q + {9'h0, gapTwo_q != 10'h3FF};
      end
   end
   pready_once_a: assert property (psel && !penable |=> pready ##1 !pready)
      else $error("pready not a single access cycle");
   slverr_map_a: assert property (psel && penable && (paddr > 8'h0C || paddr[1:0] != 2'h0)
      |-> pslverr) else $error("unmapped access without error");
   read_zero_a: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
      else $error("refused read returned data");
   status_code_a: assert property (pready && !pwrite && paddr == jog_pkg::STATUS_OFS
      |-> prdata[4:0] == buckOneCode || prdata[4:0] == $past(buckOneCode))
      else $error("status code differs from delivered code");
   step_one_a: assert property ($changed(buckOneCode) |->
      buckOneCode == $past(buckOneCode) + 5'h1 || buckOneCode == $past(buckOneCode) - 5'h1)
      else $error("switcher one moved more than one code");
   step_two_a: assert property ($changed(buckTwoCode) |->
      buckTwoCode == $past(buckTwoCode) + 5'h1 || buckTwoCode == $past(buckTwoCode) - 5'h1)
      else $error("switcher two moved more than one code");
   gap_one_a: assert property ($changed(buckOneCode) |-> gapOne_q >= 10'd98)
      else $error("switcher one stepped too soon");
   gap_two_a: assert property ($changed(buckTwoCode) |-> gapTwo_q >= 10'd98)
      else $error("switcher two stepped too soon");
   code_up_c: cover property (buckOneCode == $past(buckOneCode) + 5'h1);
   code_down_c: cover property (buckOneCode == $past(buckOneCode) - 5'h1);
   refused_c: cover property (pready && pslverr);
   standby_c: cover property (standbyPin && secondaryStandbyIn && $changed(buckOneCode));
endmodule
bind buck_setpoint_jog_control jog_control_checker chk (.clk(clk), .rstn(rstn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .serialClk(serialClk), .selectPinOne(selectPinOne),
   .selectPinTwo(selectPinTwo), .standbyPin(standbyPin),
   .secondaryStandbyIn(secondaryStandbyIn), .buckOneCode(buckOneCode),
   .buckTwoCode(buckTwoCode));

// ### testbench/jog_host_model.sv
// host processor model: select pin pulses with serial clock bursts
module jog_host_model (
   output logic serialClk,
   output logic selectPinOne,
   output logic selectPinTwo
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      serialClk = 1'b0;
      selectPinOne = 1'b0;
      selectPinTwo = 1'b0;
   end
   // pin held high around all edges
   task automatic pulse(input logic pinTwo, input int edges);
      if (pinTwo) selectPinTwo = 1'b1;
      else selectPinOne = 1'b1;
      #100;
      // clock only runs inside the frame, 30 ns period
      repeat (edges) begin
         serialClk = 1'b1;
         #15;
         serialClk = 1'b0;
         #15;
      end
      #100;
      selectPinOne = 1'b0;
      selectPinTwo = 1'b0;
      #200;
   endtask
endmodule

// ### testbench/buck_setpoint_jog_control_bench.sv
// self-checking bench for the set-point jog block
`define CHECK(nm, ex, got) begin samplesChecked++; if ((got) !== (ex)) begin badCount++; \
   $display("mismatch %s expected %h seen %h", nm, ex, got); end end
module buck_setpoint_jog_control_bench;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic serialClk;
   logic selectPinOne;
   logic selectPinTwo;
   logic standbyPin = 1'b0;
   logic secondaryStandbyIn = 1'b0;
   logic [4:0] buckOneCode;
   logic [4:0] buckTwoCode;
   logic [31:0] lfsr = 32'h9C0B1E3C;
   logic [31:0] rd;
   logic err;
   int badCount = 0;
   int samplesChecked = 0;
   int cyc = 0;
   int g;
   buck_setpoint_jog_control dut (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .serialClk(serialClk), .selectPinOne(selectPinOne),
      .selectPinTwo(selectPinTwo), .standbyPin(standbyPin),
      .secondaryStandbyIn(secondaryStandbyIn), .buckOneCode(buckOneCode),
      .buckTwoCode(buckTwoCode));
   jog_host_model host (.serialClk(serialClk), .selectPinOne(selectPinOne),
      .selectPinTwo(selectPinTwo));
   initial begin
      forever #10 clk = ~clk;
   end
   function automatic logic [31:0] cfg(input logic [4:0] n, input logic [4:0] s,
      input logic [1:0] r, input logic [3:0] lo, input logic [3:0] hi);
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      return {7'h0, hi, lo, r, s, lfsr[4:0], n}; // random alternate code
   endfunction
   // step period in cycles: 2 us doubled per rate code
   function automatic int period(input int r);
      return (2000 << r) / 20;
   endfunction
   task automatic tally_and_finish();
      $display("checked %0d mismatches %0d", samplesChecked, badCount);
      if (badCount == 0 && samplesChecked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // one apb transfer; answer is taken at the edge where pready is high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      // only pready or the bench timeout ends this wait
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic expectCode(input logic two, input logic [4:0] ex, input int lim);
      int n;
      n = 0;
      while ((two ? buckTwoCode : buckOneCode) !== ex && n < lim) begin
         @(negedge clk);
         n++;
      end
      `CHECK("code", ex, two ? buckTwoCode : buckOneCode)
   endtask
   // cycles between the next two moves of switcher one
   task automatic stepGap(output int gap);
      logic [4:0] c;
      for (int k = 0; k < 2; k++) begin
         c = buckOneCode;
         gap = 0;
         while (buckOneCode === c && gap < 5000) begin
            @(negedge clk);
            gap++;
         end
      end
   endtask
   // cycle ceiling guards against a hang
   always @(posedge clk) begin
      cyc++;
      if (cyc == 60000) begin
         badCount++;
         tally_and_finish();
      end
   end
   initial begin
      repeat (8) @(posedge clk);
      rstn <= 1'b1;
      expectCode(0, 5'h1A, 0);
      apb(0, jog_pkg::BUCK_ONE_OFS, 32'h0);
      `CHECK("cfg", {7'h0, 4'hA, 4'h8, 2'h1, 5'h10, 5'h1A, 5'h1A}, rd)
      apb(1, 8'h10, 32'hFFFFFFFF);
      apb(0, 8'h10, 32'h0);
      `CHECK("slverr", 1'b1, err)
      `CHECK("unmapped", 32'h0, rd)
      apb(1, jog_pkg::BUCK_ONE_OFS, cfg(5'h1A, 5'h10, 2'h0, 4'h8, 4'hA));
      apb(1, jog_pkg::BUCK_TWO_OFS, cfg(5'h1A, 5'h10, 2'h0, 4'h8, 4'hA));
      apb(1, jog_pkg::CTRL_OFS, 32'h1);
      host.pulse(0, 1);
      expectCode(0, 5'h19, 300);
      host.pulse(1, 1);
      expectCode(1, 5'h19, 300);
      expectCode(0, 5'h19, 0);
      repeat (150) @(posedge clk);
      host.pulse(0, 0);
      host.pulse(0, 2);
      expectCode(0, 5'h1A, 300);
      repeat (150) @(posedge clk);
      host.pulse(0, 2);
      repeat (300) @(posedge clk);
      expectCode(0, 5'h1A, 0);
      host.pulse(0, 1);
      host.pulse(0, 1);
      repeat (300) @(posedge clk);
      expectCode(0, 5'h19, 0);
      host.pulse(0, 1);
      host.pulse(0, 3);
      expectCode(0, 5'h1A, 600);
      // each rate code sets the step spacing
      for (int r = 0; r < 4; r++) begin
         apb(1, jog_pkg::BUCK_ONE_OFS, cfg(5'h1A, 5'h10, 2'(r), 4'h8, 4'hA));
         for (int k = 0; k < 2; k++) begin
            repeat (period(r) + 20) @(posedge clk);
            host.pulse(0, 1);
         end
         expectCode(0, 5'h18, 2 * period(r));
         repeat (period(r) + 20) @(posedge clk);
         // the first move starts inside the pulse, so time it alongside
         fork
            host.pulse(0, 3);
            stepGap(g);
         join
         `CHECK("gap", 1'b1, g >= period(r) - 1 && g <= period(r) + 2)
      end
      // new normal code rebases the jog copy
      apb(1, jog_pkg::BUCK_ONE_OFS, cfg(5'h0A, 5'h0C, 2'h0, 4'h9, 4'hA));
      expectCode(0, 5'h0A, 2500);
      repeat (150) @(posedge clk);
      host.pulse(0, 1);
      expectCode(0, 5'h09, 300);
      repeat (150) @(posedge clk);
      host.pulse(0, 1);
      repeat (300) @(posedge clk);
      expectCode(0, 5'h09, 0);
      apb(0, jog_pkg::BUCK_ONE_OFS, 32'h0);
      `CHECK("normal", 5'h0A, rd[4:0])
      apb(0, jog_pkg::STATUS_OFS, 32'h0);
      `CHECK("status code", 5'h09, rd[4:0])
      `CHECK("status copy", 5'h09, rd[14:10])
      @(posedge clk);
      standbyPin <= 1'b1;
      secondaryStandbyIn <= 1'b1;
      expectCode(0, 5'h0C, 600);
      @(posedge clk);
      standbyPin <= 1'b0;
      secondaryStandbyIn <= 1'b0;
      expectCode(0, 5'h0A, 600);
      tally_and_finish();
   end
endmodule
